//--- cmpdc_edge_det.sv
// Rising and falling edge detectors feeding the sticky event flag.
`timescale 1ns/1ps
module cmpdc_edge_det
    import cmpdc_pkg::*;
(
    // Clock and reset.
    input  wire logic  i_clk,
    input  wire logic  i_srst,
    // Link to the control top.
    cmpdc_edge_if.det  edge_bus
);
    typedef struct packed {
        logic prev;
        logic flag;
    } cmpdc_det_s;

    cmpdc_det_s state;
    cmpdc_det_s next_state;
    logic       rise_hit;
    logic       fall_hit;

    assign edge_bus.flag = state.flag;

    always_comb begin
        next_state = state;
        rise_hit   = edge_bus.observed & ~state.prev & edge_bus.rise_en;
        fall_hit   = ~edge_bus.observed & state.prev & edge_bus.fall_en;
        next_state.prev = edge_bus.observed;
        // A clear only ever comes from software; an edge in the same cycle keeps the flag.
        if (edge_bus.clear) begin
            next_state.flag = 1'b0;
        end
        if (rise_hit | fall_hit) begin
            next_state.flag = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule

//--- cmpdc_edge_if.sv
// Interface between the control top and its edge detector.
`timescale 1ns/1ps
interface cmpdc_edge_if;
    logic observed;
    logic rise_en;
    logic fall_en;
    logic clear;
    logic flag;
    modport ctrl (output observed, output rise_en, output fall_en, output clear, input flag);
    modport det  (input observed, input rise_en, input fall_en, input clear, output flag);
endinterface

//--- cmpdc_pkg.sv
// Package with register map, field positions and select codes of the comparator control.
package cmpdc_pkg;
    localparam logic [7:0] CMPDC_OFS_MAIN  = 8'h00;
    localparam logic [7:0] CMPDC_OFS_EDGE  = 8'h04;
    localparam logic [7:0] CMPDC_OFS_NSEL  = 8'h08;
    localparam logic [7:0] CMPDC_OFS_PSEL  = 8'h0C;
    localparam logic [7:0] CMPDC_OFS_FLAG  = 8'h10;
    localparam logic [7:0] CMPDC_OFS_IRQEN = 8'h14;
    // Main control fields.
    localparam int CMPDC_MAIN_EN   = 7;
    localparam int CMPDC_MAIN_RES  = 6;
    localparam int CMPDC_MAIN_INV  = 4;
    localparam int CMPDC_MAIN_HYS  = 1;
    localparam int CMPDC_MAIN_SYNC = 0;
    // Edge control, flag and interrupt enable fields.
    localparam int CMPDC_EDGE_RISE = 1;
    localparam int CMPDC_EDGE_FALL = 0;
    localparam int CMPDC_FLAG_BIT  = 0;
    localparam int CMPDC_IRQEN_BIT = 0;
    localparam logic [7:0] CMPDC_RST_MAIN = 8'h00;
    localparam logic [7:0] CMPDC_RST_EDGE = 8'h00;
    localparam logic [7:0] CMPDC_RST_NSEL = 8'h00;
    localparam logic [7:0] CMPDC_RST_PSEL = 8'h00;
    // Negative input codes.
    localparam logic [2:0] CMPDC_N_GND   = 3'h7;
    localparam logic [2:0] CMPDC_N_FVR2  = 3'h6;
    localparam logic [2:0] CMPDC_N_RAMP2 = 3'h5;
    localparam logic [2:0] CMPDC_N_RAMP1 = 3'h4;
    // Positive input codes; anything above selects ground.
    localparam logic [2:0] CMPDC_P_PIN  = 3'h0;
    localparam logic [2:0] CMPDC_P_RAMP = 3'h1;
    localparam logic [2:0] CMPDC_P_DAC  = 3'h2;
    localparam logic [2:0] CMPDC_P_FVR  = 3'h3;
    // Bus phase of the slave.
    typedef enum logic [2:0] {
        CMPDC_IDLE  = 3'b001,
        CMPDC_WRITE = 3'b010,
        CMPDC_READ  = 3'b100
    } cmpdc_phase_e;
endpackage

//--- cmpdc_top.sv
// Digital control of one analog comparator with an AHB-Lite register slave.
// What this block does
// - Hysteresis is applied only while its enable bit is one.
// - With latching on, timer and software see the timer-clocked copy of the result.
// - Latching captures the result on the falling edge of the gate timer clock.
// - The latching clock is the prescaled timer clock, after the prescaler.
// - The gate timer counts on the rising edge, opposite the latching edge.
// - Two separate detectors watch the output, one rising, one falling.
// - Rising enable at bit 1 lets a low-to-high change set the flag.
// - Falling enable at bit 0 lets a high-to-low change set the flag.
// - An enabled edge in the clearing cycle leaves the flag set.
// - Toggling polarity or enable while disabled acts as an output edge.
// - With the comparator disabled all inputs are disconnected.
// - Positive select routes pin, ramp, DAC, fixed reference or ground.
// - Negative select decodes ground, reference 2, ramps 2 and 1, pins 3 to 0.
// - A shared pin with an active op-amp output feeds the op-amp instead.
`timescale 1ns/1ps
module cmpdc_top
    import cmpdc_pkg::*;
(
    // Clock and reset.
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    // AHB-Lite slave.
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // Analog comparator and gate timer.
    input  wire logic        i_cmp_raw,
    input  wire logic        i_tmr_clk,
    input  wire logic [3:0]  i_opamp_active,
    // Analog controls.
    output logic             o_hysteresis_enable,
    output logic             o_inputs_connect,
    output logic      [4:0]  o_pos_route,
    output logic      [7:0]  o_neg_route,
    output logic             o_neg_from_opamp,
    // Results and flags.
    output logic             o_cmp_result,
    output logic             o_cmp_event_flag,
    output logic             o_cmp_irq_enable
);
    typedef struct packed {
        cmpdc_phase_e phase;
        logic [7:0]   addr;
        logic [31:0]  rdata;
        logic [7:0]   main_ctrl;
        logic [7:0]   edge_ctrl;
        logic [2:0]   neg_sel;
        logic [2:0]   pos_sel;
        logic         irq_en;
        logic         raw_s1;
        logic         raw_s2;
        logic         tmr_s1;
        logic         tmr_s2;
        logic         tmr_s3;
        logic         latched;
        logic         result;
        logic [4:0]   pos_route;
        logic [7:0]   neg_route;
        logic         neg_opamp;
    } cmpdc_top_s;

    cmpdc_top_s   state;
    cmpdc_top_s   next_state;
    cmpdc_edge_if edge_bus ();
    logic         addr_ok;
    logic         flag_clear;
    logic         enabled;
    logic         polar;
    logic         chosen;

    cmpdc_edge_det u_edge (
        .i_clk    (i_clk),
        .i_srst   (i_srst),
        .edge_bus (edge_bus)
    );

    // Negative select decode; out of reach when the comparator is off.
    function automatic logic [7:0] neg_decode(input logic en, input logic [2:0] sel);
        neg_decode = 8'h00;
        if (en) begin
            neg_decode = 8'h01 << sel;
        end
    endfunction

    // Byte address of a word on the bus, used for every decode.
    function automatic logic [7:0] word_addr(input logic [31:0] a);
        word_addr = {a[7:2], 2'b00};
    endfunction

    assign addr_ok    = i_hsel & i_htrans[1] & i_hready;
    assign enabled    = state.main_ctrl[CMPDC_MAIN_EN];
    assign flag_clear = (state.phase == CMPDC_WRITE) && (state.addr == CMPDC_OFS_FLAG)
                        && i_hwdata[CMPDC_FLAG_BIT];

    assign edge_bus.observed = state.result;
    assign edge_bus.rise_en  = state.edge_ctrl[CMPDC_EDGE_RISE];
    assign edge_bus.fall_en  = state.edge_ctrl[CMPDC_EDGE_FALL];
    assign edge_bus.clear    = flag_clear;

    assign o_hrdata            = state.rdata;
    assign o_hreadyout         = (state.phase != CMPDC_READ);
    assign o_hresp             = 1'b0;
    assign o_hysteresis_enable = state.main_ctrl[CMPDC_MAIN_HYS] & enabled;
    assign o_inputs_connect    = enabled;
    assign o_pos_route         = state.pos_route;
    assign o_neg_route         = state.neg_route;
    assign o_neg_from_opamp    = state.neg_opamp;
    assign o_cmp_result        = state.result;
    assign o_cmp_event_flag    = edge_bus.flag;
    assign o_cmp_irq_enable    = state.irq_en;

    always_comb begin
        next_state = state;
        polar      = 1'b0;
        chosen     = 1'b0;

        // Two-stage synchronisers for the analog result and the timer clock pin.
        next_state.raw_s1 = i_cmp_raw;
        next_state.raw_s2 = state.raw_s1;
        next_state.tmr_s1 = i_tmr_clk;
        next_state.tmr_s2 = state.tmr_s1;
        next_state.tmr_s3 = state.tmr_s2;

        // A disabled comparator's raw output is masked low before polarity, so enable and polarity toggles still move it.
        polar = (state.raw_s2 & enabled) ^ state.main_ctrl[CMPDC_MAIN_INV];

        // The pin carries the already prescaled timer clock; capture on its fall.
        if (state.tmr_s3 & ~state.tmr_s2) begin
            next_state.latched = polar;
        end
        // With latching on the gate only moves at a falling edge, so a rising count edge never meets it.
        chosen = state.main_ctrl[CMPDC_MAIN_SYNC] ? state.latched : polar;
        next_state.result = chosen;

        // Input routing.
        next_state.neg_route = neg_decode(enabled, state.neg_sel);
        next_state.neg_opamp = 1'b0;
        if (enabled && state.neg_sel[2] == 1'b0) begin
            next_state.neg_opamp = i_opamp_active[state.neg_sel[1:0]];
        end
        next_state.pos_route = 5'h00;
        if (enabled) begin
            case (state.pos_sel)
                CMPDC_P_PIN: begin
                    next_state.pos_route = 5'h01;
                end
                CMPDC_P_RAMP: begin
                    next_state.pos_route = 5'h02;
                end
                CMPDC_P_DAC: begin
                    next_state.pos_route = 5'h04;
                end
                CMPDC_P_FVR: begin
                    next_state.pos_route = 5'h08;
                end
                default: begin
                    next_state.pos_route = 5'h10;
                end
            endcase
        end

        // Bus data phase.
        case (state.phase)
            CMPDC_WRITE: begin
                case (state.addr)
                    CMPDC_OFS_MAIN: begin
                        next_state.main_ctrl = i_hwdata[7:0] & 8'h93;
                    end
                    CMPDC_OFS_EDGE: begin
                        next_state.edge_ctrl = i_hwdata[7:0] & 8'h03;
                    end
                    CMPDC_OFS_NSEL: begin
                        next_state.neg_sel = i_hwdata[2:0];
                    end
                    CMPDC_OFS_PSEL: begin
                        next_state.pos_sel = i_hwdata[2:0];
                    end
                    CMPDC_OFS_IRQEN: begin
                        next_state.irq_en = i_hwdata[CMPDC_IRQEN_BIT];
                    end
                    default: begin
                        next_state.irq_en = state.irq_en;
                    end
                endcase
            end
            CMPDC_READ: begin
                next_state.rdata = 32'h0000_0000;
                case (state.addr)
                    CMPDC_OFS_MAIN: begin
                        next_state.rdata[7:0] = state.main_ctrl;
                        next_state.rdata[CMPDC_MAIN_RES] = state.result;
                    end
                    CMPDC_OFS_EDGE: begin
                        next_state.rdata[7:0] = state.edge_ctrl;
                    end
                    CMPDC_OFS_NSEL: begin
                        next_state.rdata[2:0] = state.neg_sel;
                    end
                    CMPDC_OFS_PSEL: begin
                        next_state.rdata[2:0] = state.pos_sel;
                    end
                    CMPDC_OFS_FLAG: begin
                        next_state.rdata[CMPDC_FLAG_BIT] = edge_bus.flag;
                    end
                    CMPDC_OFS_IRQEN: begin
                        next_state.rdata[CMPDC_IRQEN_BIT] = state.irq_en;
                    end
                    default: begin
                        next_state.rdata = 32'h0000_0000;
                    end
                endcase
            end
            default: begin
                next_state.rdata = state.rdata;
            end
        endcase

        // Address phase; a read waits one cycle so it sees a write just before it.
        if (state.phase == CMPDC_READ) begin
            next_state.phase = CMPDC_IDLE;
        end else if (addr_ok) begin
            next_state.addr  = word_addr(i_haddr);
            next_state.phase = i_hwrite ? CMPDC_WRITE : CMPDC_READ;
        end else begin
            next_state.phase = CMPDC_IDLE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state           <= '0;
            state.phase     <= CMPDC_IDLE;
            state.main_ctrl <= CMPDC_RST_MAIN;
            state.edge_ctrl <= CMPDC_RST_EDGE;
            state.neg_sel   <= CMPDC_RST_NSEL[2:0];
            state.pos_sel   <= CMPDC_RST_PSEL[2:0];
        end else begin
            state <= next_state;
        end
    end
endmodule

//--- cmpdc_top_sva.sv
// Port checker of the comparator control block.
`timescale 1ns/1ps
module cmpdc_top_sva
    import cmpdc_pkg::*;
(
    // Clock, reset and bus.
    input wire logic        i_clk,
    input wire logic        i_srst,
    input wire logic        i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic        i_hready,
    input wire logic        o_hreadyout,
    input wire logic        o_hresp,
    // Comparator side.
    input wire logic [3:0]  i_opamp_active,
    input wire logic        o_hysteresis_enable,
    input wire logic        o_inputs_connect,
    input wire logic [4:0]  o_pos_route,
    input wire logic [7:0]  o_neg_route,
    input wire logic        o_neg_from_opamp,
    input wire logic        o_cmp_result,
    input wire logic        o_cmp_event_flag
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    logic take;
    logic clr_q;
    assign take = i_hsel && i_htrans[1] && i_hready;
    // Marks the data phase of a write to the flag register, the only legal clear.
    always_ff @(posedge i_clk) clr_q <= take && i_hwrite && (i_haddr[7:0] == CMPDC_OFS_FLAG);
    hys_gate_a: assert property (o_hysteresis_enable |-> o_inputs_connect)
        else $error("hysteresis on while disabled");
    inputs_off_a: assert property (!o_inputs_connect && !$past(o_inputs_connect) |->
        o_pos_route == 5'h00 && o_neg_route == 8'h00) else $error("inputs left connected");
    neg_onehot_a: assert property ($onehot0(o_neg_route))
        else $error("negative route not one-hot");
    pos_onehot_a: assert property (o_inputs_connect && $past(o_inputs_connect) |->
        $onehot(o_pos_route)) else $error("positive route not one-hot");
    opamp_pin_a: assert property (o_neg_from_opamp |->
        (o_neg_route[3:0] & $past(i_opamp_active)) != 4'h0) else $error("op-amp feed bad");
    flag_cause_a: assert property ($rose(o_cmp_event_flag) |->
        $past(o_cmp_result) != $past(o_cmp_result, 2)) else $error("flag without edge");
    flag_sticky_a: assert property ($fell(o_cmp_event_flag) |-> $past(clr_q))
        else $error("flag cleared by hardware");
    rd_wait_a: assert property (take && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
        else $error("read wait state wrong");
    wr_fast_a: assert property (take && i_hwrite |=> o_hreadyout)
        else $error("write stalled");
    resp_okay_a: assert property (o_hresp == 1'b0)
        else $error("response not okay");
    cover property ($rose(o_cmp_event_flag));
    cover property (o_neg_from_opamp);
    cover property (take && !i_hwrite);
endmodule
bind cmpdc_top cmpdc_top_sva i_sva (.i_clk, .i_srst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
    .i_hready, .o_hreadyout, .o_hresp, .i_opamp_active, .o_hysteresis_enable,
    .o_inputs_connect, .o_pos_route, .o_neg_route, .o_neg_from_opamp, .o_cmp_result,
    .o_cmp_event_flag);

//--- tb_top.sv
// Self-checking testbench of the comparator control block.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module tb_top
    import cmpdc_pkg::*;
;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} cmpdc_row_s;
    logic        i_clk = 1'b0;
    logic        i_srst = 1'b1;
    logic        i_hsel = 1'b0;
    logic [31:0] i_haddr = 32'h0;
    logic [1:0]  i_htrans = 2'h0;
    logic        i_hwrite = 1'b0;
    logic [2:0]  i_hsize = 3'h2;
    logic [31:0] i_hwdata = 32'h0;
    logic        i_hready;
    logic        i_cmp_raw = 1'b0;
    logic        i_tmr_clk = 1'b1;
    logic [3:0]  i_opamp_active = 4'h0;
    logic [31:0] o_hrdata;
    logic        o_hreadyout, o_hresp, o_hysteresis_enable, o_inputs_connect;
    logic [4:0]  o_pos_route;
    logic [7:0]  o_neg_route;
    logic        o_neg_from_opamp, o_cmp_result, o_cmp_event_flag, o_cmp_irq_enable;
    int          n_errors = 0;
    int          samples_checked = 0;
    logic [31:0] r;
    cmpdc_row_s  rows [7] = '{'{CMPDC_OFS_EDGE, 32'hFF, 32'h03}, '{CMPDC_OFS_NSEL, 32'hFF, 32'h07},
        '{CMPDC_OFS_PSEL, 32'h05, 32'h05}, '{CMPDC_OFS_IRQEN, 32'h01, 32'h01},
        '{8'h20, 32'hFF, 32'h00}, '{CMPDC_OFS_MAIN, 32'hFF, 32'h93},
        '{CMPDC_OFS_MAIN, 32'h02, 32'h02}};
    assign i_hready = o_hreadyout;
    cmpdc_top i_dut (.i_clk, .i_srst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize,
        .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .i_cmp_raw, .i_tmr_clk,
        .i_opamp_active, .o_hysteresis_enable, .o_inputs_connect, .o_pos_route, .o_neg_route,
        .o_neg_from_opamp, .o_cmp_result, .o_cmp_event_flag, .o_cmp_irq_enable);
    initial begin
        forever #4 i_clk = ~i_clk;
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // A stuck slave must end the run instead of hanging it.
    task automatic hold(inout int k);
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while (o_hreadyout !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_errors++;
            give_verdict();
        end
    endtask
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge i_clk);
        i_hsel <= 1'b1;
        i_htrans <= 2'h2;
        i_haddr <= {24'h0, a};
        i_hwrite <= w;
        hold(k);
        i_hsel <= 1'b0;
        i_htrans <= 2'h0;
        i_hwdata <= d;
        hold(k);
        r = o_hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(a, 1'b1, d);
    endtask
    task automatic nap(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    initial begin
        nap(12);
        i_srst <= 1'b0;
        for (int i = 0; i < 24; i += 4) begin
            ahb(8'(i), 1'b0, 32'h0);
            `CHK(r, 32'h0)
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            ahb(rows[i].a, 1'b0, 32'h0);
            `CHK(r, rows[i].e)
        end
        `CHK(o_cmp_irq_enable, 1'b1)
        `CHK(o_hysteresis_enable, 1'b0)
        wr(CMPDC_OFS_MAIN, 32'h82);
        nap(2);
        `CHK(o_hysteresis_enable, 1'b1)
        for (int i = 0; i < 8; i++) begin
            wr(CMPDC_OFS_NSEL, i);
            wr(CMPDC_OFS_PSEL, i);
            nap(2);
            `CHK(o_neg_route, 8'h01 << i)
            `CHK(o_pos_route, 5'h01 << (i > 4 ? 4 : i))
        end
        wr(CMPDC_OFS_NSEL, 32'h2);
        i_opamp_active <= 4'h4;
        nap(3);
        `CHK(o_neg_from_opamp, 1'b1)
        i_opamp_active <= 4'h2;
        nap(3);
        `CHK(o_neg_from_opamp, 1'b0)
        wr(CMPDC_OFS_MAIN, 32'h0);
        nap(2);
        `CHK({o_inputs_connect, o_pos_route, o_neg_route}, 14'h0)
        wr(CMPDC_OFS_EDGE, 32'h2);
        wr(CMPDC_OFS_MAIN, 32'h80);
        nap(6);
        `CHK(o_hysteresis_enable, 1'b0)
        wr(CMPDC_OFS_FLAG, 32'h1);
        nap(2);
        `CHK(o_cmp_event_flag, 1'b0)
        for (int m = 0; m < 2; m++) begin
            wr(CMPDC_OFS_EDGE, m ? 32'h1 : 32'h2);
            i_cmp_raw <= 1'b1;
            nap(6);
            `CHK({o_cmp_result, o_cmp_event_flag}, m ? 2'b10 : 2'b11)
            wr(CMPDC_OFS_FLAG, 32'h1);
            i_cmp_raw <= 1'b0;
            nap(6);
            `CHK({o_cmp_result, o_cmp_event_flag}, m ? 2'b01 : 2'b00)
            wr(CMPDC_OFS_FLAG, 32'h1);
        end
        // The edge reaches the detector in the very cycle that clears the flag.
        wr(CMPDC_OFS_EDGE, 32'h2);
        i_cmp_raw <= 1'b1;
        nap(1);
        wr(CMPDC_OFS_FLAG, 32'h1);
        nap(1);
        `CHK(o_cmp_event_flag, 1'b1)
        wr(CMPDC_OFS_MAIN, 32'h0);
        wr(CMPDC_OFS_EDGE, 32'h3);
        wr(CMPDC_OFS_FLAG, 32'h1);
        wr(CMPDC_OFS_MAIN, 32'h10);
        nap(6);
        `CHK({o_cmp_result, o_cmp_event_flag}, 2'b11)
        wr(CMPDC_OFS_FLAG, 32'h1);
        wr(CMPDC_OFS_MAIN, 32'h81);
        i_cmp_raw <= 1'b1;
        nap(10);
        `CHK(o_cmp_result, 1'b0)
        i_tmr_clk <= 1'b0;
        nap(8);
        `CHK(o_cmp_result, 1'b1)
        ahb(CMPDC_OFS_MAIN, 1'b0, 32'h0);
        `CHK(r, 32'hC1)
        // A reset in mid-run drops the flag, the latched result and every register.
        i_srst <= 1'b1;
        nap(3);
        i_srst <= 1'b0;
        nap(1);
        `CHK({o_cmp_result, o_cmp_event_flag, o_hreadyout}, 3'b001)
        ahb(CMPDC_OFS_MAIN, 1'b0, 32'h0);
        `CHK(r, 32'h0)
        give_verdict();
    end
endmodule
